/* File: rtl/ccsa_top.sv */
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ccsa_top
    import ccsa_pkg::*;
#(
    parameter int NUM_CH = CCSA_NUM_CH
) (
    input wire logic clock, // 40 MHz clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [NUM_CH-1:0] overrun_flag, // data overrun per channel
    input wire logic [NUM_CH-1:0] rx_buffer_full, // receive buffer holds a message
    input wire logic [NUM_CH-1:0] rx_active, // message being received
    input wire logic [NUM_CH-1:0] bus_off_flag, // channel barred from bus
    input wire logic [NUM_CH-1:0] error_warning, // error warning limit exceeded
    input wire logic [NUM_CH-1:0] message_object_receive_mode, // reception goes to object slot
    input wire logic [CCSA_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [CCSA_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic irq // interrupt, high while an unmasked event is pending
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [NUM_CH-1:0] overrun_ff;
    logic [NUM_CH-1:0] rx_buf_ff;
    logic [NUM_CH-1:0] overrun_prev_ff;
    logic [NUM_CH-1:0] bus_off_prev_ff;
    logic [NUM_CH-1:0] err_warn_prev_ff;
    logic [31:0] int_status_ff;
    logic [31:0] int_mask_ff;
    logic irq_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [CCSA_ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] rx_word;
    logic [31:0] bus_err_word;
    logic [31:0] events;
    logic [31:0] byte_mask;
    logic do_write;
    logic wr_clear;
    logic wr_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // Overrun and buffer flags follow the controller except during object-slot reception.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overrun_ff <= CCSA_RST_OVERRUN;
            rx_buf_ff <= CCSA_RST_RX_BUF;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!message_object_receive_mode[i]) begin
                    overrun_ff[i] <= overrun_flag[i];
                    rx_buf_ff[i] <= rx_buffer_full[i];
                end
            end
        end
    end

    // Status words; bits outside the fields stay zero.
    always_comb begin
        rx_word = 32'h0000_0000;
        rx_word[CCSA_RX_ACTIVE_LSB +: NUM_CH] = rx_active;
        rx_word[CCSA_RX_BUF_LSB +: NUM_CH] = rx_buf_ff;
        rx_word[CCSA_OVERRUN_LSB +: NUM_CH] = overrun_ff;
        bus_err_word = 32'h0000_0000;
        bus_err_word[CCSA_ERR_WARN_LSB +: NUM_CH] = error_warning;
        bus_err_word[CCSA_BUS_OFF_LSB +: NUM_CH] = bus_off_flag;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rising edges of overrun, bus-off and error-warning raise interrupt events.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overrun_prev_ff <= CCSA_RST_OVERRUN;
            bus_off_prev_ff <= '0;
            err_warn_prev_ff <= '0;
        end else begin
            overrun_prev_ff <= overrun_ff;
            bus_off_prev_ff <= bus_off_flag;
            err_warn_prev_ff <= error_warning;
        end
    end

    always_comb begin
        events = 32'h0000_0000;
        events[CCSA_OVERRUN_LSB +: NUM_CH] = overrun_ff & ~overrun_prev_ff;
        events[CCSA_BUS_OFF_LSB +: NUM_CH] = bus_off_flag & ~bus_off_prev_ff;
        events[CCSA_ERR_WARN_LSB +: NUM_CH] = error_warning & ~err_warn_prev_ff;
    end

    assign byte_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_clear = do_write && (waddr_ff == CCSA_OFS_INT_STATUS);
    assign wr_mask = do_write && (waddr_ff == CCSA_OFS_INT_MASK);

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_status_ff <= 32'h0000_0000;
        end else if (wr_clear) begin
            int_status_ff <= (int_status_ff & ~(wdata_ff & byte_mask)) | events;
        end else begin
            int_status_ff <= int_status_ff | events;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_mask_ff <= CCSA_RST_INT_MASK;
        end else if (wr_mask) begin
            int_mask_ff <= (int_mask_ff & ~byte_mask) | (wdata_ff & byte_mask);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_status_ff & int_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write address and data are taken independently and held until the response.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            waddr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
        end
    end

    // Writes to the status words are accepted and dropped.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= CCSA_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            unique case (waddr_ff)
                CCSA_OFS_RX_STATUS: bresp_ff <= CCSA_RESP_OKAY;
                CCSA_OFS_BUS_ERR: bresp_ff <= CCSA_RESP_OKAY;
                CCSA_OFS_INT_STATUS: bresp_ff <= CCSA_RESP_OKAY;
                CCSA_OFS_INT_MASK: bresp_ff <= CCSA_RESP_OKAY;
                default: bresp_ff <= CCSA_RESP_SLVERR;
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is captured in the cycle the address is accepted.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= CCSA_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= CCSA_RESP_OKAY;
            unique case (s_axi_araddr)
                CCSA_OFS_RX_STATUS: rdata_ff <= rx_word;
                CCSA_OFS_BUS_ERR: rdata_ff <= bus_err_word;
                CCSA_OFS_INT_STATUS: rdata_ff <= int_status_ff;
                CCSA_OFS_INT_MASK: rdata_ff <= int_mask_ff;
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= CCSA_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign irq = irq_ff;

endmodule

/* File: rtl/ccsa_pkg.sv */
package ccsa_pkg;

    localparam int CCSA_NUM_CH = 6;
    localparam int CCSA_ADDR_W = 4;

    // Register byte offsets.
    localparam logic [CCSA_ADDR_W-1:0] CCSA_OFS_RX_STATUS = 4'h0;
    localparam logic [CCSA_ADDR_W-1:0] CCSA_OFS_BUS_ERR = 4'h4;
    localparam logic [CCSA_ADDR_W-1:0] CCSA_OFS_INT_STATUS = 4'h8;
    localparam logic [CCSA_ADDR_W-1:0] CCSA_OFS_INT_MASK = 4'hc;

    // Field positions in the receive-status word.
    localparam int CCSA_RX_ACTIVE_LSB = 0;
    localparam int CCSA_RX_BUF_LSB = 8;
    localparam int CCSA_OVERRUN_LSB = 16;

    // Field positions in the bus-error-status word.
    localparam int CCSA_ERR_WARN_LSB = 0;
    localparam int CCSA_BUS_OFF_LSB = 8;

    // Reset values of the per-channel flags and of the interrupt mask.
    localparam logic [CCSA_NUM_CH-1:0] CCSA_RST_RX_ACTIVE = 6'h3f;
    localparam logic [CCSA_NUM_CH-1:0] CCSA_RST_RX_BUF = 6'h00;
    localparam logic [CCSA_NUM_CH-1:0] CCSA_RST_OVERRUN = 6'h00;
    localparam logic [31:0] CCSA_RST_INT_MASK = 32'h0000_0000;

    // AXI4-Lite response codes.
    localparam logic [1:0] CCSA_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCSA_RESP_SLVERR = 2'h2;

endpackage

/* File: verification/ccsa_checker.sv */
`timescale 1ns/1ps
module ccsa_checker
    import ccsa_pkg::*;
#(
    parameter int NUM_CH = CCSA_NUM_CH
) (
    input wire logic clock, // clock
    input wire logic resetn, // reset
    input wire logic [NUM_CH-1:0] overrun_flag, // overrun
    input wire logic [NUM_CH-1:0] rx_buffer_full, // buffer full
    input wire logic [NUM_CH-1:0] rx_active, // receiving
    input wire logic [NUM_CH-1:0] bus_off_flag, // bus off
    input wire logic [NUM_CH-1:0] error_warning, // warning
    input wire logic [NUM_CH-1:0] message_object_receive_mode, // freeze
    input wire logic [CCSA_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // r valid
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid // b valid
);
    logic [CCSA_ADDR_W-1:0] addr_ff;
    logic rd_rx;
    logic rd_be;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    assign rd_rx = s_axi_rvalid && addr_ff == CCSA_OFS_RX_STATUS;
    assign rd_be = s_axi_rvalid && addr_ff == CCSA_OFS_BUS_ERR;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) addr_ff <= 4'h0;
        else if (s_axi_arvalid && s_axi_arready) addr_ff <= s_axi_araddr;
    end
    property p_rx_act; $rose(s_axi_rvalid) && rd_rx |-> s_axi_rdata[5:0] == $past(rx_active);
    endproperty
    a_rx_act: assert property (p_rx_act) else $error("receive activity field wrong");
    property p_rx_copy; $rose(s_axi_rvalid) && rd_rx && $past(resetn, 2)
        && $past(message_object_receive_mode, 2) == 6'h00
        |-> s_axi_rdata[21:8] == {$past(overrun_flag, 2), 2'h0, $past(rx_buffer_full, 2)};
    endproperty
    a_rx_copy: assert property (p_rx_copy) else $error("overrun or buffer field wrong");
    property p_rx_rsv; rd_rx |-> s_axi_rdata[31:22] == 10'h0 && s_axi_rdata[15:14] == 2'h0
        && s_axi_rdata[7:6] == 2'h0;
    endproperty
    a_rx_rsv: assert property (p_rx_rsv) else $error("receive word unused bits set");
    property p_be_rsv; rd_be |-> s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[7:6] == 2'h0;
    endproperty
    a_be_rsv: assert property (p_be_rsv) else $error("bus error word unused bits set");
    property p_bus_off; $rose(s_axi_rvalid) && rd_be |-> s_axi_rdata[13:8] == $past(bus_off_flag);
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus off field wrong");
    property p_warn; $rose(s_axi_rvalid) && rd_be |-> s_axi_rdata[5:0] == $past(error_warning);
    endproperty
    a_warn: assert property (p_warn) else $error("error warning field wrong");
    property p_snap; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_snap: assert property (p_snap) else $error("read answer not next cycle");
    property p_bresp; $rose(s_axi_bvalid) |-> s_axi_bresp == CCSA_RESP_OKAY;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response not okay");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ccsa_top ccsa_checker #(.NUM_CH(NUM_CH)) i_chk (
    .clock(clock), .resetn(resetn), .overrun_flag(overrun_flag),
    .rx_buffer_full(rx_buffer_full), .rx_active(rx_active), .bus_off_flag(bus_off_flag),
    .error_warning(error_warning), .message_object_receive_mode(message_object_receive_mode),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid)
);

/* File: verification/can_central_status_aggregator_tb.sv */
`timescale 1ns/1ps
module can_central_status_aggregator_tb;
    import ccsa_pkg::*;
    logic clock, resetn, aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, irq;
    logic [5:0] ovr, rbf, rxa, bof, ewf, mor, ov_m, rb_m, ovp, bop, ewp;
    logic [3:0] aw_addr, ar_addr, w_strb;
    logic [1:0] b_resp, r_resp;
    logic [31:0] w_data, r_data, d, st_m, mask_m;
    logic [31:0] exp_q[$];
    int miscompares, comparisons, seed, i;
    ccsa_top i_dut (.clock(clock), .resetn(resetn), .overrun_flag(ovr), .rx_buffer_full(rbf),
        .rx_active(rxa), .bus_off_flag(bof), .error_warning(ewf),
        .message_object_receive_mode(mor), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
        .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .irq(irq));
    function automatic logic [31:0] exp_word(input logic [3:0] a);
        case (a)
            4'h0: return {10'h0, ov_m, 2'h0, rb_m, 2'h0, rxa};
            4'h4: return {18'h0, bof, 2'h0, ewf};
            4'h8: return st_m;
            default: return mask_m;
        endcase
    endfunction
    // Reference model: flag copies freeze per channel, rising edges latch status.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {ov_m, rb_m, ovp, bop, ewp} <= 30'h0;
            st_m <= 32'h0;
        end else begin
            if (ar_valid && ar_ready) exp_q.push_back(exp_word(ar_addr));
            ov_m <= (ov_m & mor) | (ovr & ~mor);
            rb_m <= (rb_m & mor) | (rbf & ~mor);
            {ovp, bop, ewp} <= {ov_m, bof, ewf};
            st_m <= st_m | {10'h0, ov_m & ~ovp, 2'h0, bof & ~bop, 2'h0, ewf & ~ewp};
        end
    end
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        @(posedge clock);
        for (int n = 0; n < 100 && ar_ready !== 1'b1; n++) @(posedge clock);
        ar_valid <= 1'b0;
        @(posedge clock);
        for (int n = 0; n < 100 && r_valid !== 1'b1; n++) @(posedge clock);
        r_ready <= 1'b0;
        chk(r_data, exp_q.pop_front());
        chk({30'h0, r_resp}, {30'h0, CCSA_RESP_OKAY});
        @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bit aw_p = 1'b1;
        bit w_p = 1'b1;
        {aw_addr, w_data, w_strb} <= {a, v, 4'hf};
        {aw_valid, w_valid, b_ready} <= 3'h7;
        for (int n = 0; n < 100 && (aw_p || w_p); n++) begin
            @(posedge clock);
            if (aw_ready === 1'b1) aw_p = 1'b0;
            if (w_ready === 1'b1) w_p = 1'b0;
            {aw_valid, w_valid} <= {aw_p, w_p};
        end
        @(posedge clock);
        for (int n = 0; n < 100 && b_valid !== 1'b1; n++) @(posedge clock);
        b_ready <= 1'b0;
        chk({30'h0, b_resp}, {30'h0, CCSA_RESP_OKAY});
        #1;
        if (a == CCSA_OFS_INT_MASK) mask_m = v;
        if (a == CCSA_OFS_INT_STATUS) st_m = st_m & ~v;
        @(posedge clock);
    endtask
    task end_sim;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_sim;
    end
    initial begin
        seed = 32'h6215ff1a;
        {ovr, rbf, bof, ewf, mor, rxa, mask_m} = {30'h0, 6'h3f, 32'h0};
        {resetn, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 6'h0;
        {aw_addr, ar_addr, w_strb, w_data} = 44'h0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        for (i = 0; i < 16; i += 4) rd(i[3:0]);
        {ovr, rbf, bof} <= 18'h3ffff;
        repeat (3) @(posedge clock);
        wr(CCSA_OFS_RX_STATUS, 32'hffffffff);
        wr(CCSA_OFS_BUS_ERR, 32'h0);
        rd(CCSA_OFS_RX_STATUS);
        rd(CCSA_OFS_BUS_ERR);
        mor <= 6'h2a;
        {ovr, rbf} <= 12'h0;
        repeat (3) @(posedge clock);
        rd(CCSA_OFS_RX_STATUS);
        wr(CCSA_OFS_INT_MASK, 32'hffffffff);
        ewf <= 6'h21;
        repeat (4) @(posedge clock);
        chk({31'h0, irq}, {31'h0, |(st_m & mask_m)});
        wr(CCSA_OFS_INT_MASK, 32'h0);
        chk({31'h0, irq}, {31'h0, |(st_m & mask_m)});
        wr(CCSA_OFS_INT_MASK, 32'hffffffff);
        wr(CCSA_OFS_INT_STATUS, 32'hffffffff);
        chk({31'h0, irq}, {31'h0, |(st_m & mask_m)});
        rd(CCSA_OFS_INT_STATUS);
        for (i = 0; i < 40; i++) begin
            d = $random(seed);
            {ovr, rbf, rxa, bof, ewf} <= d[29:0];
            d = $random(seed);
            mor <= d[5:0];
            repeat (1 + d[7:6]) @(posedge clock);
            rd({d[9:8], 2'h0});
        end
        repeat (4) @(posedge clock);
        chk({31'h0, irq}, {31'h0, |(st_m & mask_m)});
        end_sim;
    end
endmodule
